/* File: design/dpc_pkg.sv */
// Shared constants and types for the dual-port RAM port controller
package dpc_pkg;

  localparam int          ADDR_W      = 15;
  localparam int          DATA_W      = 8;
  localparam int          TOKEN_SEL_W = 3;
  localparam int          CNT_W       = 4;

  localparam int          CLK_MHZ     = 10;
  localparam int          SETUP_NS    = 20;
  localparam int          STROBE_NS   = 60;
  localparam int          RECOVER_NS  = 20;

  localparam logic [ADDR_W-1:0] MBOX_LEFT_ADDR  = 15'h7ffe;
  localparam logic [ADDR_W-1:0] MBOX_RIGHT_ADDR = 15'h7fff;

  localparam logic [1:0]  STEP_REQ   = 2'h0;
  localparam logic [1:0]  STEP_CHECK = 2'h1;
  localparam logic [1:0]  STEP_FREE  = 2'h2;

  // Least time to whole cycles, rounded up, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SETUP_CYC   = ns_to_cyc(SETUP_NS);
  localparam int STROBE_CYC  = ns_to_cyc(STROBE_NS);
  localparam int RECOVER_CYC = ns_to_cyc(RECOVER_NS);

  localparam logic [CNT_W-1:0] SETUP_LD   = CNT_W'(SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] STROBE_LD  = CNT_W'(STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] RECOVER_LD = CNT_W'(RECOVER_CYC - 1);

  typedef enum logic [2:0] {
    DPC_OP_RAM_RD,
    DPC_OP_RAM_WR,
    DPC_OP_POST,
    DPC_OP_ACK,
    DPC_OP_TOK_GET,
    DPC_OP_TOK_PUT,
    DPC_OP_TOK_RD
  } dpc_op_e;

  typedef enum logic [1:0] {
    S_IDLE,
    S_SETUP,
    S_STROBE,
    S_RECOVER
  } dpc_state_e;

endpackage

/* File: design/dpc_timer.sv */
// Down-counting phase timer
module dpc_timer #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         en,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              done
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (load) begin
      next_cnt = value;
    end else if (cnt != '0) begin
      next_cnt = cnt - W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
    end else if (en) begin
      cnt <= next_cnt;
    end
  end

  assign done = (cnt == '0);
endmodule

/* File: design/dpc_port_ctrl.sv */
// Host controller for one port of the dual-port RAM
// What this block does
// - Right port clears its flag by reading 7FFF.
// - In slave role, hold contention input high; low blocks writes.
// - Exactly one master per wide array; the rest are slaves.
// - Address and select settle before the write strobe starts.
// - Request token, read back; on failure re-read or withdraw.
module dpc_port_ctrl
  import dpc_pkg::*;
#(
  parameter bit IS_LEFT     = 1'b1,
  parameter int TOKEN_TRIES = 4
) (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic                          en,
  input  wire logic                          cmd_valid,
  output logic                               cmd_ready,
  input  wire dpc_pkg::dpc_op_e              cmd_op,
  input  wire logic [dpc_pkg::ADDR_W-1:0]    cmd_addr,
  input  wire logic [dpc_pkg::DATA_W-1:0]    cmd_wdata,
  output logic                               rsp_valid,
  output logic [dpc_pkg::DATA_W-1:0]         rsp_rdata,
  output logic                               rsp_contention,
  output logic                               rsp_token_won,
  output logic                               mailbox_pending,
  input  wire logic                          cfg_master,
  input  wire logic                          cfg_block_writes,
  output logic                               ram_select_n,
  output logic                               token_latch_select_n,
  output logic                               rw_n,
  output logic                               out_en_n,
  output logic [dpc_pkg::ADDR_W-1:0]         addr,
  output logic [dpc_pkg::DATA_W-1:0]         data_o,
  input  wire logic [dpc_pkg::DATA_W-1:0]    data_i,
  output logic                               data_oe,
  output logic                               role_select,
  input  wire logic                          busy_n_i,
  output logic                               busy_n_o,
  output logic                               busy_n_oe,
  input  wire logic                          own_mailbox_flag_n
);
  import dpc_pkg::*;

  localparam int TRY_W = $clog2(TOKEN_TRIES + 1);
  localparam logic [ADDR_W-1:0] OWN_MBOX =
    IS_LEFT ? MBOX_LEFT_ADDR : MBOX_RIGHT_ADDR;
  localparam logic [ADDR_W-1:0] FAR_MBOX =
    IS_LEFT ? MBOX_RIGHT_ADDR : MBOX_LEFT_ADDR;

  dpc_state_e        state;
  dpc_state_e        next_state;
  dpc_op_e           op;
  dpc_op_e           next_op;
  logic [1:0]        step;
  logic [1:0]        next_step;
  logic [TRY_W-1:0]  tries;
  logic [TRY_W-1:0]  next_tries;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] next_data_o;
  logic              is_sem;
  logic              next_is_sem;
  logic              is_wr;
  logic              next_is_wr;
  logic [DATA_W-1:0] next_rsp_rdata;
  logic              next_rsp_valid;
  logic              next_rsp_contention;
  logic              next_rsp_token_won;
  logic              next_mailbox_pending;
  logic              next_role_select;
  logic              next_busy_n_o;
  logic              tmr_load;
  logic [CNT_W-1:0]  tmr_value;
  logic              tmr_done;
  logic              active;

  dpc_timer #(.W(CNT_W)) u_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .en    (en),
    .load  (tmr_load),
    .value (tmr_value),
    .done  (tmr_done)
  );

  always_comb begin
    next_state           = state;
    next_op              = op;
    next_step            = step;
    next_tries           = tries;
    next_addr            = addr;
    next_data_o          = data_o;
    next_is_sem          = is_sem;
    next_is_wr           = is_wr;
    next_rsp_rdata       = rsp_rdata;
    next_rsp_valid       = 1'b0;
    next_rsp_contention  = rsp_contention;
    next_rsp_token_won   = rsp_token_won;
    next_mailbox_pending = !own_mailbox_flag_n;
    next_role_select     = cfg_master;
    next_busy_n_o        = !cfg_block_writes;
    tmr_load             = 1'b0;
    tmr_value            = SETUP_LD;
    unique case (state)
      S_IDLE: begin
        if (cmd_valid) begin
          next_op             = cmd_op;
          next_step           = STEP_REQ;
          next_tries          = TRY_W'(TOKEN_TRIES);
          next_rsp_contention = 1'b0;
          next_rsp_token_won  = 1'b0;
          next_addr           = cmd_addr;
          next_data_o         = cmd_wdata;
          next_is_sem         = 1'b0;
          next_is_wr          = 1'b0;
          unique case (cmd_op)
            DPC_OP_RAM_RD: next_is_wr = 1'b0;
            DPC_OP_RAM_WR: next_is_wr = 1'b1;
            DPC_OP_POST: begin
              next_addr  = FAR_MBOX;
              next_is_wr = 1'b1;
            end
            DPC_OP_ACK: next_addr = OWN_MBOX;
            DPC_OP_TOK_GET, DPC_OP_TOK_PUT, DPC_OP_TOK_RD: begin
              next_addr   = {{(ADDR_W-TOKEN_SEL_W){1'b0}},
                             cmd_addr[TOKEN_SEL_W-1:0]};
              next_is_sem = 1'b1;
              next_is_wr  = (cmd_op != DPC_OP_TOK_RD);
              next_data_o = (cmd_op == DPC_OP_TOK_PUT) ? '1 : '0;
            end
            default: next_is_wr = 1'b0;
          endcase
          next_state = S_SETUP;
          tmr_load   = 1'b1;
          tmr_value  = SETUP_LD;
        end
      end
      S_SETUP: begin
        if (tmr_done) begin
          next_state = S_STROBE;
          tmr_load   = 1'b1;
          tmr_value  = STROBE_LD;
        end
      end
      S_STROBE: begin
        if (tmr_done) begin
          if (!is_wr) begin
            next_rsp_rdata = data_i;
          end
          if (role_select && !busy_n_i) begin
            next_rsp_contention = 1'b1;
          end
          next_state = S_RECOVER;
          tmr_load   = 1'b1;
          tmr_value  = RECOVER_LD;
        end
      end
      S_RECOVER: begin
        if (tmr_done) begin
          next_state = S_IDLE;
          next_rsp_valid = 1'b1;
          if (op == DPC_OP_TOK_GET && step == STEP_REQ) begin
            next_step  = STEP_CHECK;
            next_is_wr = 1'b0;
          end else if (op == DPC_OP_TOK_GET && step == STEP_CHECK) begin
            if (!rsp_rdata[0]) begin
              next_rsp_token_won = 1'b1;
            end else if (tries != '0) begin
              next_tries = tries - TRY_W'(1);
            end else begin
              next_step   = STEP_FREE;
              next_is_wr  = 1'b1;
              next_data_o = '1;
            end
          end
          if (next_state == S_IDLE && op == DPC_OP_TOK_GET &&
              (step == STEP_REQ || (step == STEP_CHECK &&
               rsp_rdata[0]))) begin
            next_state     = S_SETUP;
            next_rsp_valid = 1'b0;
            tmr_load       = 1'b1;
            tmr_value      = SETUP_LD;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state           <= S_IDLE;
      op              <= DPC_OP_RAM_RD;
      step            <= STEP_REQ;
      tries           <= '0;
      addr            <= '0;
      data_o          <= '0;
      is_sem          <= 1'b0;
      is_wr           <= 1'b0;
      rsp_rdata       <= '0;
      rsp_valid       <= 1'b0;
      rsp_contention  <= 1'b0;
      rsp_token_won   <= 1'b0;
      mailbox_pending <= 1'b0;
      role_select     <= 1'b0;
      busy_n_o        <= 1'b1;
    end else if (en) begin
      state           <= next_state;
      op              <= next_op;
      step            <= next_step;
      tries           <= next_tries;
      addr            <= next_addr;
      data_o          <= next_data_o;
      is_sem          <= next_is_sem;
      is_wr           <= next_is_wr;
      rsp_rdata       <= next_rsp_rdata;
      rsp_valid       <= next_rsp_valid;
      rsp_contention  <= next_rsp_contention;
      rsp_token_won   <= next_rsp_token_won;
      mailbox_pending <= next_mailbox_pending;
      role_select     <= next_role_select;
      busy_n_o        <= next_busy_n_o;
    end
  end

  // Pin strobes
  assign active    = (state == S_SETUP) || (state == S_STROBE);
  assign cmd_ready = en && (state == S_IDLE);
  assign ram_select_n         = !(active && !is_sem);
  assign token_latch_select_n = !(active && is_sem);
  assign rw_n      = !((state == S_STROBE) && is_wr);
  assign out_en_n  = !((state == S_STROBE) && !is_wr);
  assign data_oe   = !(active && is_wr);
  assign busy_n_oe = role_select;

  // Checks
  property p_standby;
    @(posedge clk) disable iff (!rst_b)
      state == S_IDLE |-> ram_select_n && token_latch_select_n;
  endproperty
  a_standby: assert property (p_standby)
    else $error("select active while idle");

  property p_setup_first;
    @(posedge clk) disable iff (!rst_b)
      $fell(rw_n) |-> $stable(addr) &&
        $past(!ram_select_n || !token_latch_select_n);
  endproperty
  a_setup_first: assert property (p_setup_first)
    else $error("write strobe without prior setup");

  property p_one_select;
    @(posedge clk) disable iff (!rst_b)
      (!rw_n || !out_en_n) |-> (ram_select_n != token_latch_select_n);
  endproperty
  a_one_select: assert property (p_one_select)
    else $error("strobe without exactly one select");

  property p_token_addr;
    @(posedge clk) disable iff (!rst_b)
      !token_latch_select_n |->
        addr[ADDR_W-1:TOKEN_SEL_W] == '0 && data_oe == !is_wr;
  endproperty
  a_token_addr: assert property (p_token_addr)
    else $error("token access with high address bits");

  property p_token_data;
    @(posedge clk) disable iff (!rst_b)
      (!token_latch_select_n && !rw_n) |-> (data_o == '0 || data_o == '1);
  endproperty
  a_token_data: assert property (p_token_data)
    else $error("token write data not uniform");

  property p_ack_own;
    @(posedge clk) disable iff (!rst_b)
      (state == S_STROBE && op == DPC_OP_ACK) |->
        !out_en_n && !ram_select_n && rw_n && addr == OWN_MBOX;
  endproperty
  a_ack_own: assert property (p_ack_own)
    else $error("mailbox clear not a read of own mailbox");

  property p_post_far;
    @(posedge clk) disable iff (!rst_b)
      (op == DPC_OP_POST && !rw_n) |-> !ram_select_n && addr == FAR_MBOX;
  endproperty
  a_post_far: assert property (p_post_far)
    else $error("mailbox post to wrong address");

  property p_role_drive;
    @(posedge clk) disable iff (!rst_b)
      en ##1 en |-> busy_n_oe == $past(cfg_master) &&
        busy_n_o == !$past(cfg_block_writes);
  endproperty
  a_role_drive: assert property (p_role_drive)
    else $error("contention pin drive wrong for role");

  property p_verify_after_req;
    @(posedge clk) disable iff (!rst_b)
      (en && op == DPC_OP_TOK_GET && step == STEP_REQ &&
       state == S_RECOVER && tmr_done) |=>
        state == S_SETUP && !is_wr && step == STEP_CHECK;
  endproperty
  a_verify_after_req: assert property (p_verify_after_req)
    else $error("token request not followed by read back");

  property p_release_gap;
    @(posedge clk) disable iff (!rst_b)
      $rose(out_en_n) && $past(!token_latch_select_n) |->
        token_latch_select_n;
  endproperty
  a_release_gap: assert property (p_release_gap)
    else $error("token select held across reads");

  c_token_won: cover property (@(posedge clk) rsp_valid && rsp_token_won);
  c_contention: cover property (@(posedge clk) rsp_valid && rsp_contention);
  c_post: cover property (@(posedge clk) op == DPC_OP_POST && !rw_n);
  c_withdraw: cover property (@(posedge clk)
    step == STEP_FREE && !rw_n);
endmodule

/* File: bench/dpc_ram_model.sv */
// Behavioural two-port RAM with mailboxes, busy logic and token latches
module dpc_ram_model (
  input  wire logic                        clk,
  input  wire logic [1:0]                  ce_n,
  input  wire logic [1:0]                  sem_n,
  input  wire logic [1:0]                  rw_n,
  input  wire logic [1:0]                  oe_n,
  input  wire logic [dpc_pkg::ADDR_W-1:0]  a [2],
  input  wire logic [dpc_pkg::DATA_W-1:0]  dout [2],
  input  wire logic [1:0]                  doe,
  output logic      [dpc_pkg::DATA_W-1:0]  din [2],
  input  wire logic                        master,
  input  wire logic [1:0]                  bo,
  input  wire logic [1:0]                  boe,
  output logic      [1:0]                  busy_n,
  output logic      [1:0]                  flag_n
);
  import dpc_pkg::*;

  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] tok_q [2];
  logic [DATA_W-1:0] last [2];
  logic [7:0]        req_n [2];
  logic [1:0]        hold [8];
  logic [1:0]        sel_q;
  logic [1:0]        arb;
  logic [1:0]        inh;
  logic              match;

  initial begin
    flag_n = 2'h3;
    sel_q = 2'h0;
    req_n = '{default: 8'hff};
    hold = '{default: 2'h0};
    last = '{default: 8'h00};
  end

  // Clash decided from selects and addresses only
  assign match = !ce_n[0] && !ce_n[1] && a[0] == a[1];
  assign arb[1] = master && match && !(sel_q[1] && !sel_q[0]);
  assign arb[0] = master && match && !arb[1];
  assign inh = master ? arb : ~busy_n;

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      busy_n[p] = boe[p] ? !arb[p] : bo[p];
      if (!doe[p])
        din[p] = dout[p];
      else if (!ce_n[p] && !oe_n[p] && rw_n[p])
        din[p] = mem[a[p]];
      else if (!sem_n[p] && !oe_n[p] && rw_n[p])
        din[p] = tok_q[p];
      else
        din[p] = ~last[p];
    end
  end

  always @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      sel_q[p] <= !ce_n[p];
      last[p] <= din[p];
      if (!ce_n[p] && !rw_n[p] && !inh[p]) begin
        mem[a[p]] <= dout[p];
        if (p == 1 && a[p] == MBOX_LEFT_ADDR)
          flag_n[0] <= 1'b0;
        if (p == 0 && a[p] == MBOX_RIGHT_ADDR)
          flag_n[1] <= 1'b0;
      end
      if (!sem_n[p] && !rw_n[p])
        req_n[p][a[p][2:0]] <= dout[p][0];
      if (sem_n[p] || oe_n[p])
        tok_q[p] <= {DATA_W{hold[a[p][2:0]] != p + 1}};
    end
    if (!ce_n[0] && !oe_n[0] && a[0] == MBOX_LEFT_ADDR)
      flag_n[0] <= 1'b1;
    if (!ce_n[1] && !oe_n[1] && rw_n[1] && a[1] == MBOX_RIGHT_ADDR)
      flag_n[1] <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      if (hold[k] == 2'h0 || req_n[hold[k] - 1][k])
        hold[k] <= !req_n[0][k] ? 2'h1 : !req_n[1][k] ? 2'h2 : 2'h0;
    end
  end
endmodule

/* File: bench/dpc_port_ctrl_bench.sv */
// Bench: two port controllers facing the two-port RAM model
module dpc_port_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import dpc_pkg::*;

  logic              clk;
  logic              rst_b;
  logic [1:0]        en, cv, cfg_m, cfg_b, rdy, rv, rc, won, pend;
  logic [1:0]        ce_n, sem_n, rw_n, oe_n, doe, role, bo, boe;
  logic [1:0]        busy_n, flag_n, prw, pcs;
  dpc_op_e           op [2];
  logic [ADDR_W-1:0] ca [2], pa [2], ppa [2];
  logic [DATA_W-1:0] wd [2], rd [2], dout [2], din [2];
  int                err_total, total_checks;

  always #50 clk = ~clk;

  for (genvar g = 0; g < 2; g++) begin : g_port
    dpc_port_ctrl #(.IS_LEFT(g == 0), .TOKEN_TRIES(4)) dut_u (
      .clk(clk), .rst_b(rst_b), .en(en[g]), .cmd_valid(cv[g]),
      .cmd_ready(rdy[g]), .cmd_op(op[g]), .cmd_addr(ca[g]),
      .cmd_wdata(wd[g]), .rsp_valid(rv[g]), .rsp_rdata(rd[g]),
      .rsp_contention(rc[g]), .rsp_token_won(won[g]),
      .mailbox_pending(pend[g]), .cfg_master(cfg_m[g]),
      .cfg_block_writes(cfg_b[g]), .ram_select_n(ce_n[g]),
      .token_latch_select_n(sem_n[g]), .rw_n(rw_n[g]),
      .out_en_n(oe_n[g]), .addr(pa[g]), .data_o(dout[g]),
      .data_i(din[g]), .data_oe(doe[g]), .role_select(role[g]),
      .busy_n_i(busy_n[g]), .busy_n_o(bo[g]), .busy_n_oe(boe[g]),
      .own_mailbox_flag_n(flag_n[g])
    );
  end

  dpc_ram_model ram_u (
    .clk(clk), .ce_n(ce_n), .sem_n(sem_n), .rw_n(rw_n), .oe_n(oe_n),
    .a(pa), .dout(dout), .doe(doe), .din(din), .master(role[0]),
    .bo(bo), .boe(boe), .busy_n(busy_n), .flag_n(flag_n)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Write strobe only after address and select stood for a cycle
  always @(negedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (rst_b && !rw_n[p] && prw[p])
        chk(pcs[p] && pa[p] == ppa[p], 1'b1);
    end
    prw <= rw_n;
    pcs <= ~(ce_n & sem_n);
    ppa <= pa;
  end

  task put(input int p, input dpc_op_e o, input logic [14:0] ad,
           input logic [7:0] d = 8'h00);
    op[p] <= o;
    ca[p] <= ad;
    wd[p] <= d;
  endtask

  task go(input logic [1:0] m);
    logic [1:0] seen;
    int         n;
    seen = 2'b00;
    n = 0;
    @(posedge clk);
    cv <= m;
    @(posedge clk);
    cv <= 2'b00;
    while ((seen & m) !== m && n < 60) begin
      #1;
      seen = seen | rv;
      @(posedge clk);
      n++;
    end
    if ((seen & m) !== m) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, seen, m);
      give_verdict();
    end
  endtask

  task look(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task t_ram;
    put(0, DPC_OP_RAM_WR, 15'h0123, 8'ha5);
    put(1, DPC_OP_RAM_WR, 15'h7ffd, 8'h5a);
    go(2'b11);
    chk(rc, 2'b00);
    put(0, DPC_OP_RAM_RD, 15'h7ffd);
    put(1, DPC_OP_RAM_RD, 15'h0123);
    go(2'b11);
    chk({rd[0], rd[1], ce_n, sem_n}, 20'h5aa5f);
    en <= 2'b10;
    look(0);
    chk(rdy, 2'b10);
    @(posedge clk);
    en <= 2'b11;
  endtask

  task t_mbox;
    put(0, DPC_OP_POST, MBOX_RIGHT_ADDR, 8'h3c);
    go(2'b01);
    look(2);
    chk(pend, 2'b10);
    @(posedge clk);
    put(1, DPC_OP_ACK, MBOX_RIGHT_ADDR);
    go(2'b10);
    chk(rd[1], 8'h3c);
    put(1, DPC_OP_POST, MBOX_LEFT_ADDR, 8'hc3);
    go(2'b10);
    look(2);
    chk(pend, 2'b01);
    @(posedge clk);
    put(0, DPC_OP_ACK, MBOX_LEFT_ADDR);
    go(2'b01);
    look(2);
    chk({rd[0], pend}, 10'h30c);
    @(posedge clk);
  endtask

  task t_clash;
    logic [1:0] c;
    put(0, DPC_OP_RAM_RD, 15'h0040);
    put(1, DPC_OP_RAM_RD, 15'h0040);
    go(2'b11);
    chk(^rc, 1'b1);
    put(0, DPC_OP_RAM_WR, 15'h0040, 8'h11);
    put(1, DPC_OP_RAM_WR, 15'h0040, 8'h22);
    go(2'b11);
    c = rc;
    chk(^c, 1'b1);
    put(0, DPC_OP_RAM_RD, 15'h0040);
    go(2'b01);
    chk({rc[0], rd[0]}, {1'b0, c[0] ? 8'h22 : 8'h11});
  endtask

  task t_token;
    put(0, DPC_OP_TOK_GET, 15'h7ffb);
    go(2'b01);
    chk(won[0], 1'b1);
    put(1, DPC_OP_TOK_GET, 15'h0003);
    put(0, DPC_OP_TOK_RD, 15'h0013);
    go(2'b11);
    chk({won[1], rd[0]}, 9'h000);
    put(0, DPC_OP_TOK_PUT, 15'h0003);
    go(2'b01);
    put(1, DPC_OP_TOK_RD, 15'h0003);
    go(2'b10);
    chk(rd[1], 8'hff);
    put(0, DPC_OP_TOK_GET, 15'h0003);
    go(2'b01);
    put(0, DPC_OP_TOK_PUT, 15'h0003);
    put(1, DPC_OP_TOK_GET, 15'h0003);
    go(2'b11);
    chk(won[1], 1'b1);
    put(1, DPC_OP_TOK_PUT, 15'h0003);
    go(2'b10);
    put(0, DPC_OP_TOK_GET, 15'h0005);
    put(1, DPC_OP_TOK_GET, 15'h0005);
    go(2'b11);
    chk(^won, 1'b1);
    put(0, DPC_OP_TOK_PUT, 15'h0005);
    put(1, DPC_OP_TOK_PUT, 15'h0005);
    go(2'b11);
  endtask

  task t_slave;
    cfg_m <= 2'b00;
    cfg_b <= 2'b01;
    look(3);
    chk({role, boe, bo}, 6'b000010);
    @(posedge clk);
    put(0, DPC_OP_RAM_WR, 15'h0123, 8'h77);
    put(1, DPC_OP_RAM_WR, 15'h0123, 8'h99);
    go(2'b11);
    chk(rc, 2'b00);
    put(0, DPC_OP_RAM_RD, 15'h0123);
    go(2'b01);
    chk(rd[0], 8'h99);
    cfg_b <= 2'b00;
    put(0, DPC_OP_RAM_WR, 15'h0123, 8'h77);
    go(2'b01);
    put(0, DPC_OP_RAM_RD, 15'h0123);
    go(2'b01);
    chk(rd[0], 8'h77);
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    en = 2'b11;
    cv = 2'b00;
    cfg_m = 2'b11;
    cfg_b = 2'b00;
    op = '{DPC_OP_RAM_RD, DPC_OP_RAM_RD};
    ca = '{default: '0};
    wd = '{default: '0};
    err_total = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_ram();
    t_mbox();
    t_clash();
    t_token();
    t_slave();
    give_verdict();
  end
endmodule
